//--- verilog/cdb_exec.sv
// Execute unit for compare-skip, decrement, decrement-skip and decimal adjust
// Function
// - Compare-less skips when file value below accumulator, unsigned, no flags, no store.
// - A taken skip discards the prefetched word and runs one no-operation cycle.
// - Skipping a two-word instruction inserts two no-operation cycles.
// - Bank bit zero selects the access bank; one selects the bank register.
// - Extended set, bank bit zero, operand up to 95: indexed literal offset.
// - Decimal adjust adds six per nibble on BCD overflow; only carry changes.
// - Decrement writes accumulator or file by destination bit, updates five flags.
// - Decrement-skip writes the chosen destination, keeps flags, skips on zero.
// - Compare-greater skips when file value above accumulator, unsigned, no store.
`timescale 1ns/10ps
module cdb_exec (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Instruction issue
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_WORD,
  input wire logic NEXT_TWO_WORD,
  // Operand sources
  input wire logic [7:0] ACC_IN,
  input wire logic [7:0] FILE_RDATA,
  input wire logic [3:0] BANK_SELECT,
  input wire logic [11:0] INDEX_BASE,
  input wire logic EXT_SET_EN,
  input wire logic [4:0] STATUS_IN,
  // File read address
  output logic [11:0] FILE_RADDR,
  // Registered results
  output logic FILE_WE,
  output logic [11:0] FILE_WADDR,
  output logic [7:0] FILE_WDATA,
  output logic ACC_WE,
  output logic [7:0] ACC_WDATA,
  output logic [4:0] STATUS_WE,
  output logic [4:0] STATUS_OUT,
  // Pipeline control
  output logic NOP_CYCLE,
  output logic DISCARD_FETCH,
  output logic INSTR_TAKEN
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [7:0] file_sel;
  logic acc_bank;
  logic dest_file;
  logic is_lt;
  logic is_gt;
  logic is_dec;
  logic is_dsz;
  logic is_daw;
  logic nop_busy;
  logic exec_ok;

  // Words matching no pattern here are still taken and simply do nothing

  // Operand fields sit in fixed slots of every file-register opcode
  assign file_sel = INSTR_WORD[cdb_pkg::FILE_LSB +: cdb_pkg::FILE_W];
  assign acc_bank = INSTR_WORD[cdb_pkg::ACC_BIT];
  assign dest_file = INSTR_WORD[cdb_pkg::DEST_BIT];

  // Opcode match, qualified by issue and no pending skip slot
  assign exec_ok = INSTR_VALID && !nop_busy;
  assign is_lt = exec_ok && (INSTR_WORD[15:9] == cdb_pkg::OPC_SKIP_LT);
  assign is_gt = exec_ok && (INSTR_WORD[15:9] == cdb_pkg::OPC_SKIP_GT);
  assign is_dec = exec_ok && (INSTR_WORD[15:10] == cdb_pkg::OPC_DEC);
  assign is_dsz = exec_ok && (INSTR_WORD[15:10] == cdb_pkg::OPC_DEC_SKIP_Z);
  assign is_daw = exec_ok && (INSTR_WORD == cdb_pkg::OPC_DEC_ADJ);

  // ----------------------------------------------------------------
  // Data address
  // ----------------------------------------------------------------
  // Combinational so the file array can answer in the same cycle
  // Index arithmetic wraps at twelve bits; software keeps the pointer in range
  always_comb begin
    FILE_RADDR = {cdb_pkg::ACCESS_LO_BANK, file_sel};
    if (acc_bank) begin
      FILE_RADDR = {BANK_SELECT, file_sel};
    end else if (EXT_SET_EN && (file_sel <= cdb_pkg::INDEX_MAX)) begin
      FILE_RADDR = INDEX_BASE + {4'h0, file_sel};
    end else if (file_sel >= cdb_pkg::ACCESS_SPLIT) begin
      FILE_RADDR = {cdb_pkg::ACCESS_HI_BANK, file_sel};
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  logic [7:0] dec_res;
  logic [4:0] dec_flags;
  logic lt_hit;
  logic gt_hit;
  logic [8:0] daw_mid;
  logic [8:0] daw_res;
  logic daw_lo_fix;
  logic daw_hi_fix;

  // Carry and half carry mean no borrow, so both fall only when the field was zero
  assign dec_res = FILE_RDATA - 8'h01;
  always_comb begin
    dec_flags = cdb_pkg::ST_RESET;
    dec_flags[cdb_pkg::ST_C] = (FILE_RDATA != cdb_pkg::BYTE_ZERO);
    dec_flags[cdb_pkg::ST_DC] = (FILE_RDATA[3:0] != 4'h0);
    dec_flags[cdb_pkg::ST_Z] = (dec_res == cdb_pkg::BYTE_ZERO);
    dec_flags[cdb_pkg::ST_OV] = (FILE_RDATA == cdb_pkg::OVF_DEC);
    dec_flags[cdb_pkg::ST_N] = dec_res[7];
  end

  // Unsigned compares; the difference itself is never kept
  assign lt_hit = (FILE_RDATA < ACC_IN);
  assign gt_hit = (FILE_RDATA > ACC_IN);

  // Low fix first, so its carry feeds the high nibble test
  assign daw_lo_fix = (ACC_IN[3:0] > cdb_pkg::BCD_MAX[3:0]) ||
                      STATUS_IN[cdb_pkg::ST_DC];
  assign daw_mid = {1'b0, ACC_IN} + (daw_lo_fix ? cdb_pkg::BCD_LO_FIX : 9'h000);
  assign daw_hi_fix = (daw_mid[8:4] > cdb_pkg::BCD_MAX) || STATUS_IN[cdb_pkg::ST_C];
  assign daw_res = daw_mid + (daw_hi_fix ? cdb_pkg::BCD_HI_FIX : 9'h000);

  // ----------------------------------------------------------------
  // Result stage
  // ----------------------------------------------------------------
  logic file_we_r;
  logic file_we_nxt;
  logic [11:0] file_waddr_r;
  logic [11:0] file_waddr_nxt;
  logic [7:0] file_wdata_r;
  logic [7:0] file_wdata_nxt;
  logic acc_we_r;
  logic acc_we_nxt;
  logic [7:0] acc_wdata_r;
  logic [7:0] acc_wdata_nxt;
  logic [4:0] st_we_r;
  logic [4:0] st_we_nxt;
  logic [4:0] st_out_r;
  logic [4:0] st_out_nxt;
  logic skip_req;

  // Only one of the decoded strobes can be high in a cycle
  // Data changes only on a decrement or adjust, address only on a decrement, even one to the other destination, and otherwise both hold the last result
  always_comb begin
    file_we_nxt = 1'b0;
    file_waddr_nxt = file_waddr_r;
    file_wdata_nxt = file_wdata_r;
    acc_we_nxt = 1'b0;
    acc_wdata_nxt = acc_wdata_r;
    st_we_nxt = cdb_pkg::ST_RESET;
    st_out_nxt = st_out_r;
    if (is_dec || is_dsz) begin
      // Destination bit low sends the result to the accumulator
      file_we_nxt = dest_file;
      acc_we_nxt = !dest_file;
      file_waddr_nxt = FILE_RADDR;
      file_wdata_nxt = dec_res;
      acc_wdata_nxt = dec_res;
      if (is_dec) begin
        st_we_nxt = 5'h1f;
        st_out_nxt = dec_flags;
      end
    end else if (is_daw) begin
      acc_we_nxt = 1'b1;
      acc_wdata_nxt = daw_res[7:0];
      st_we_nxt = 5'h01 << cdb_pkg::ST_C;
      st_out_nxt = STATUS_IN;
      st_out_nxt[cdb_pkg::ST_C] = STATUS_IN[cdb_pkg::ST_C] || daw_hi_fix || daw_mid[8];
    end
  end


  // Compare forms never touch status or storage, they only request a skip
  // Decrement-skip tests the fresh result, not the old file value
  assign skip_req = (is_lt && lt_hit) || (is_gt && gt_hit) ||
                    (is_dsz && (dec_res == cdb_pkg::BYTE_ZERO));

  // Result registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      file_we_r <= 1'b0;
      file_waddr_r <= 12'h000;
      file_wdata_r <= 8'h00;
      acc_we_r <= 1'b0;
      acc_wdata_r <= 8'h00;
      st_we_r <= cdb_pkg::ST_RESET;
      st_out_r <= cdb_pkg::ST_RESET;
    end else begin
      file_we_r <= file_we_nxt;
      file_waddr_r <= file_waddr_nxt;
      file_wdata_r <= file_wdata_nxt;
      acc_we_r <= acc_we_nxt;
      acc_wdata_r <= acc_wdata_nxt;
      st_we_r <= st_we_nxt;
      st_out_r <= st_out_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Skip slots
  // ----------------------------------------------------------------
  // Issue is ignored in slot cycles: the word presented then is the victim
  // A two-word victim's operand word falls into the extra slot and is never decoded
  cdb_skip_seq u_skip (
    .clk(CLK),
    .rst(SYS_RST),
    .skip_req(skip_req),
    .next_two_word(NEXT_TWO_WORD),
    .nop_cycle(nop_busy),
    .discard_fetch(DISCARD_FETCH)
  );

  // Output wiring
  // Taken mirrors the decode qualifier, so the issuer knows when to retire the word
  assign NOP_CYCLE = nop_busy;
  assign INSTR_TAKEN = exec_ok;
  assign FILE_WE = file_we_r;
  assign FILE_WADDR = file_waddr_r;
  assign FILE_WDATA = file_wdata_r;
  assign ACC_WE = acc_we_r;
  assign ACC_WDATA = acc_wdata_r;
  assign STATUS_WE = st_we_r;
  assign STATUS_OUT = st_out_r;

endmodule // cdb_exec

//--- verilog/cdb_pkg.sv
// Shared constants for the compare, decrement and decimal-adjust execution block
package cdb_pkg;

  // ----------------------------------------------------------------
  // Instruction field layout
  // ----------------------------------------------------------------
  localparam int FILE_LSB = 0;
  localparam int FILE_W = 8;
  localparam int ACC_BIT = 8;
  localparam int DEST_BIT = 9;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [6:0] OPC_SKIP_LT = 7'h30;    // 0110 000a
  localparam logic [6:0] OPC_SKIP_GT = 7'h32;    // 0110 010a
  localparam logic [5:0] OPC_DEC = 6'h01;        // 0000 01da
  localparam logic [5:0] OPC_DEC_SKIP_Z = 6'h0b; // 0010 11da
  localparam logic [15:0] OPC_DEC_ADJ = 16'h0007;

  // ----------------------------------------------------------------
  // Addressing constants
  // ----------------------------------------------------------------
  localparam logic [7:0] INDEX_MAX = 8'h5f;      // 95
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // ----------------------------------------------------------------
  // Decimal adjust and status layout
  // ----------------------------------------------------------------
  localparam logic [4:0] BCD_MAX = 5'h09;
  localparam logic [8:0] BCD_LO_FIX = 9'h006;
  localparam logic [8:0] BCD_HI_FIX = 9'h060;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  localparam int ST_W = 5;
  localparam logic [4:0] ST_RESET = 5'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] OVF_DEC = 8'h80;

  // Skip sequencer states
  typedef enum logic [1:0] {
    CDB_RUN = 2'b00,
    CDB_NOP_LAST = 2'b01,
    CDB_NOP_FIRST = 2'b10
  } cdb_skip_t;

endpackage

//--- verilog/cdb_skip_seq.sv
// Skip sequencer: turns a skip request into one or two no-operation cycles
`timescale 1ns/10ps
module cdb_skip_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the execute stage
  input wire logic skip_req,
  input wire logic next_two_word,
  // Pipeline control
  output logic nop_cycle,
  output logic discard_fetch
);

  cdb_pkg::cdb_skip_t state_r;
  cdb_pkg::cdb_skip_t state_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A two-word victim needs a second slot, else its operand word would execute
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cdb_pkg::CDB_RUN: begin
        if (skip_req) begin
          state_nxt = next_two_word ? cdb_pkg::CDB_NOP_FIRST : cdb_pkg::CDB_NOP_LAST;
        end
      end
      cdb_pkg::CDB_NOP_FIRST: state_nxt = cdb_pkg::CDB_NOP_LAST;
      cdb_pkg::CDB_NOP_LAST: state_nxt = cdb_pkg::CDB_RUN;
      default: state_nxt = cdb_pkg::CDB_RUN;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= cdb_pkg::CDB_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Prefetched word is dropped in each slot and a no-operation runs instead
  assign nop_cycle = (state_r != cdb_pkg::CDB_RUN);
  assign discard_fetch = nop_cycle;

endmodule // cdb_skip_seq

//--- testbench/cdb_exec_assertions.sv
// Assertion checker for the execute unit
`timescale 1ns/10ps
module cdb_exec_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Issue and operands
  input wire logic INSTR_TAKEN,
  input wire logic [15:0] INSTR_WORD,
  input wire logic NEXT_TWO_WORD,
  input wire logic [7:0] ACC_IN,
  input wire logic [7:0] FILE_RDATA,
  input wire logic [3:0] BANK_SELECT,
  input wire logic [11:0] INDEX_BASE,
  input wire logic EXT_SET_EN,
  // Results
  input wire logic [11:0] FILE_RADDR,
  input wire logic FILE_WE,
  input wire logic [11:0] FILE_WADDR,
  input wire logic ACC_WE,
  input wire logic [7:0] ACC_WDATA,
  input wire logic [4:0] STATUS_WE,
  input wire logic NOP_CYCLE
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Slot lengths after a taken skip
  sequence one_slot; NOP_CYCLE ##1 !NOP_CYCLE; endsequence
  sequence two_slot; NOP_CYCLE [*2] ##1 !NOP_CYCLE; endsequence
  chk_lt_skip: assert property (INSTR_TAKEN && INSTR_WORD[15:9] == cdb_pkg::OPC_SKIP_LT
    && FILE_RDATA < ACC_IN |=> NOP_CYCLE && !ACC_WE && !FILE_WE && STATUS_WE == 5'h00)
    else $error("less compare missed its skip");
  chk_gt_skip: assert property (INSTR_TAKEN && INSTR_WORD[15:9] == cdb_pkg::OPC_SKIP_GT
    && FILE_RDATA > ACC_IN |=> NOP_CYCLE && !ACC_WE && !FILE_WE) else $error("greater skip missed");
  chk_one_slot: assert property ($rose(NOP_CYCLE) && !$past(NEXT_TWO_WORD) |-> one_slot)
    else $error("single slot length wrong");
  chk_two_slot: assert property ($rose(NOP_CYCLE) && $past(NEXT_TWO_WORD) |-> two_slot)
    else $error("double slot length wrong");
  chk_dec_acc: assert property (INSTR_TAKEN && INSTR_WORD[15:9] == {cdb_pkg::OPC_DEC, 1'b0}
    |=> ACC_WE && !FILE_WE && ACC_WDATA == $past(FILE_RDATA) - 8'h01 && STATUS_WE == 5'h1f)
    else $error("decrement to accumulator wrong");
  chk_dec_file: assert property (INSTR_TAKEN && INSTR_WORD[15:9] == {cdb_pkg::OPC_DEC, 1'b1}
    |=> FILE_WE && !ACC_WE && FILE_WADDR == $past(FILE_RADDR)) else $error("decrement file wrong");
  chk_dsz_skip: assert property (INSTR_TAKEN && INSTR_WORD[15:10] == cdb_pkg::OPC_DEC_SKIP_Z
    |=> STATUS_WE == 5'h00 && NOP_CYCLE == ($past(FILE_RDATA) == 8'h01))
    else $error("decrement skip wrong");
  chk_daw_carry: assert property (INSTR_TAKEN && INSTR_WORD == cdb_pkg::OPC_DEC_ADJ
    |=> ACC_WE && STATUS_WE == 5'h01) else $error("decimal adjust strobes wrong");
  chk_bank_addr: assert property (INSTR_WORD[8]
    |-> FILE_RADDR == {BANK_SELECT, INSTR_WORD[7:0]}) else $error("bank address wrong");
  chk_index_addr: assert property (INSTR_WORD[15:12] == 4'h6 && !INSTR_WORD[8] && EXT_SET_EN
    && INSTR_WORD[7:0] <= cdb_pkg::INDEX_MAX |-> FILE_RADDR == INDEX_BASE + {4'h0, INSTR_WORD[7:0]})
    else $error("indexed address wrong");
endmodule // cdb_exec_assertions

bind cdb_exec cdb_exec_assertions u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .INSTR_TAKEN(INSTR_TAKEN),
  .INSTR_WORD(INSTR_WORD), .NEXT_TWO_WORD(NEXT_TWO_WORD), .ACC_IN(ACC_IN), .FILE_RDATA(FILE_RDATA),
  .BANK_SELECT(BANK_SELECT), .INDEX_BASE(INDEX_BASE), .EXT_SET_EN(EXT_SET_EN),
  .FILE_RADDR(FILE_RADDR), .FILE_WE(FILE_WE), .FILE_WADDR(FILE_WADDR), .ACC_WE(ACC_WE),
  .ACC_WDATA(ACC_WDATA), .STATUS_WE(STATUS_WE), .NOP_CYCLE(NOP_CYCLE));

//--- testbench/tb.sv
// Self-checking bench for the execute unit
`timescale 1ns/10ps
module tb;
  logic CLK, SYS_RST, INSTR_VALID, NEXT_TWO_WORD, EXT_SET_EN, FILE_WE, ACC_WE;
  logic NOP_CYCLE, DISCARD_FETCH, INSTR_TAKEN, aw_s, fw_s;
  logic [15:0] INSTR_WORD;
  logic [7:0] ACC_IN, FILE_RDATA, ACC_WDATA, FILE_WDATA, ad_s, fd_s, r, v;
  logic [3:0] BANK_SELECT;
  logic [11:0] INDEX_BASE, FILE_RADDR, FILE_WADDR, wa_s, ea;
  logic [4:0] STATUS_IN, STATUS_WE, STATUS_OUT, sw_s, so_s;
  logic [8:0] r9;
  logic [7:0] cv[4] = '{8'h7f, 8'h80, 8'h01, 8'hff};
  logic [7:0] dv[5] = '{8'h00, 8'h01, 8'h10, 8'h80, 8'h5a};
  logic [7:0] da[6] = '{8'ha5, 8'hce, 8'h19, 8'h12, 8'h9a, 8'h99};
  logic [4:0] ds[6] = '{5'h00, 5'h00, 5'h02, 5'h01, 5'h00, 5'h03};
  int mismatches, comparisons;
  cdb_exec uut (.CLK(CLK), .SYS_RST(SYS_RST), .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD),
    .NEXT_TWO_WORD(NEXT_TWO_WORD), .ACC_IN(ACC_IN), .FILE_RDATA(FILE_RDATA),
    .BANK_SELECT(BANK_SELECT), .INDEX_BASE(INDEX_BASE), .EXT_SET_EN(EXT_SET_EN),
    .STATUS_IN(STATUS_IN), .FILE_RADDR(FILE_RADDR), .FILE_WE(FILE_WE), .FILE_WADDR(FILE_WADDR),
    .FILE_WDATA(FILE_WDATA), .ACC_WE(ACC_WE), .ACC_WDATA(ACC_WDATA), .STATUS_WE(STATUS_WE),
    .STATUS_OUT(STATUS_OUT), .NOP_CYCLE(NOP_CYCLE), .DISCARD_FETCH(DISCARD_FETCH),
    .INSTR_TAKEN(INSTR_TAKEN));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // Operand address from current bank, index and mode settings
  function automatic logic [11:0] eaddr(input logic [15:0] w);
    if (w[8]) return {BANK_SELECT, w[7:0]};
    if (EXT_SET_EN && w[7:0] <= 8'h5f) return INDEX_BASE + {4'h0, w[7:0]};
    return {(w[7:0] < 8'h60) ? 4'h0 : 4'hf, w[7:0]};
  endfunction
  // Low fix carry feeds the high test
  function automatic logic [8:0] decimal_adjust_acc(input logic [7:0] a, input logic c, dc);
    logic [8:0] t;
    logic h;
    t = {1'b0, a};
    if (t[3:0] > 4'h9 || dc) t = t + 9'h006;
    h = (t[8:4] > 5'h09) || c;
    if (h) t = t + 9'h060;
    return {c | h | t[8], t[7:0]};
  endfunction
  // One issue; a victim word is offered in each slot and must be refused
  task automatic exec(input logic [15:0] w, input logic [7:0] f, a, input logic [4:0] s,
      input logic two, skip);
    @(posedge CLK);
    INSTR_VALID <= 1'b1;
    INSTR_WORD <= w;
    FILE_RDATA <= f;
    ACC_IN <= a;
    STATUS_IN <= s;
    NEXT_TWO_WORD <= two;
    #1 ea = eaddr(w);
    if (w != cdb_pkg::OPC_DEC_ADJ) chk("raddr", ea, FILE_RADDR);
    chk("taken", 1, INSTR_TAKEN);
    @(posedge CLK);
    INSTR_VALID <= skip;
    INSTR_WORD <= 16'h0000;
    FILE_RDATA <= ~f;
    #1 {aw_s, fw_s, sw_s, so_s} = {ACC_WE, FILE_WE, STATUS_WE, STATUS_OUT};
    {ad_s, fd_s, wa_s} = {ACC_WDATA, FILE_WDATA, FILE_WADDR};
    chk("skip", {skip, skip}, {NOP_CYCLE, DISCARD_FETCH});
    if (skip) chk("victim", 0, INSTR_TAKEN);
    if (skip && two) begin
      @(posedge CLK);
      #1 chk("slot2", 1, NOP_CYCLE);
      chk("victim2", 0, INSTR_TAKEN);
    end
    if (skip) begin
      @(posedge CLK);
      INSTR_VALID <= 1'b0;
      #1 chk("resume", 0, NOP_CYCLE);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // Whole run needs well under 400 cycles
  initial begin
    repeat (3000) @(posedge CLK);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {SYS_RST, INSTR_VALID, NEXT_TWO_WORD, EXT_SET_EN} = 4'h8;
    {INSTR_WORD, ACC_IN, FILE_RDATA, STATUS_IN} = '0;
    {BANK_SELECT, INDEX_BASE} = '0;
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    #1 chk("reset", 0, {ACC_WE, FILE_WE, STATUS_WE, NOP_CYCLE});
    // Both compares over bank modes, the 95/96 boundary and victim lengths
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 2; j++) begin
        @(posedge CLK);
        EXT_SET_EN <= i[1];
        BANK_SELECT <= 4'h3 + 4'(i);
        INDEX_BASE <= 12'hfe0;
        v = cv[i % 4];
        exec({j ? cdb_pkg::OPC_SKIP_GT : cdb_pkg::OPC_SKIP_LT, i[0], (i < 4) ? 8'h5f : 8'h60},
          v, 8'h80, 5'h1f, i[2], j ? v > 8'h80 : v < 8'h80);
        chk("cmp_we", 0, {aw_s, fw_s, sw_s});
      end
    end
    // Decrement to both destinations, borrow and overflow corners
    for (int i = 0; i < 10; i++) begin
      v = dv[i / 2];
      r = v - 8'h01;
      exec({cdb_pkg::OPC_DEC, i[0], 1'b1, 8'h40 + 8'(i)}, v, 8'h33, 5'h00, 1'b0, 1'b0);
      chk("dec_dest", {i[0], !i[0]}, {fw_s, aw_s});
      chk("dec_data", r, i[0] ? fd_s : ad_s);
      chk("dec_flags", {5'h1f, r[7], v == 8'h80, r == 8'h00, v[3:0] != 4'h0, v != 8'h00},
        {sw_s, so_s});
      if (i[0]) chk("dec_addr", ea, wa_s);
    end
    // Decrement-skip: zero result skips, flags untouched
    for (int i = 0; i < 6; i++) begin
      v = dv[i / 2];
      exec({cdb_pkg::OPC_DEC_SKIP_Z, i[0], 1'b0, 8'h07}, v, 8'h00, 5'h1f, i[0], v == 8'h01);
      chk("dsz", {i[0], !i[0], 5'h00, v - 8'h01}, {fw_s, aw_s, sw_s, i[0] ? fd_s : ad_s});
    end
    // Decimal adjust over flag combinations
    for (int i = 0; i < 6; i++) begin
      r9 = decimal_adjust_acc(da[i], ds[i][0], ds[i][1]);
      exec(cdb_pkg::OPC_DEC_ADJ, 8'h00, da[i], ds[i], 1'b0, 1'b0);
      chk("daw", {1'b1, 5'h01, r9}, {aw_s, sw_s, so_s[0], ad_s});
    end
    report_and_stop();
  end
endmodule // tb
